/* design/encoder_position_capture_regs.svh */
// Register offsets, field positions and constants of the encoder position block
`ifndef ENCODER_POSITION_CAPTURE_REGS_SVH
`define ENCODER_POSITION_CAPTURE_REGS_SVH

`define REG_CTRL     8'h00
`define REG_CMD      8'h04
`define REG_INIT     8'h08
`define REG_RELOAD   8'h0C
`define REG_POS      8'h10
`define REG_STATUS   8'h14
`define REG_SAMPLE   8'h18

`define CTRL_MODE    0
`define CTRL_ZEN     1
`define CTRL_ZPH_LO  2
`define CTRL_ZPH_HI  3
`define CTRL_SFALL   4

`define CMD_START    0
`define CMD_STOP     1

`define STAT_ARMED   0
`define STAT_EMPTY   1
`define STAT_FULL    2
`define STAT_OVF     3
`define STAT_CNT_LO  8
`define STAT_CNT_HI  11

`define PIN_A        0
`define PIN_B        1
`define PIN_Z        2
`define PIN_S        3

`define WORD_ZERO    32'h0000_0000
`define POS_ONE      32'h0000_0001
`define PTR_ONE      3'h1
`define CNT_ZERO     4'h0
`define CNT_ONE      4'h1
`define CNT_DEPTH    4'h8

`endif

/* design/encoder_position_capture_pkg.sv */
// Types shared by the encoder position block and its pin synchroniser
package encoder_position_capture_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_RUN  = 2'h2
	} run_e;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] stable;
	} sync_s;

	typedef struct packed {
		run_e            st;
		logic [31:0]     pos;
		logic [31:0]     init;
		logic [31:0]     reload;
		logic            mode;
		logic            zen;
		logic [1:0]      zph;
		logic            sfall;
		logic            a;
		logic            b;
		logic            z;
		logic            s;
		logic [7:0][31:0] mem;
		logic [2:0]      wr;
		logic [2:0]      rd;
		logic [3:0]      cnt;
		logic            ovf;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
	} epc_s;

endpackage

/* design/pin_sync.sv */
// Three-stage synchroniser with agreement filter for the encoder and sample clock pins
module pin_sync
	import encoder_position_capture_pkg::*;
(
	input  logic       pclk,
	input  logic       presetn,
	input  logic [3:0] pin_raw,
	output logic [3:0] pin_clean
);

	sync_s q;
	sync_s d;

	// Stage one feeds stage two only; a change is taken once stages two and three agree
	always_comb begin
		d = q;
		d.s1 = pin_raw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < 4; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.stable[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pin_clean = q.stable;

endmodule

/* design/encoder_position_capture.sv */
// Quadrature position counter with index reload, on-demand reads and sample-clock capture
//
// Overview of operation
// - Start command presets the position counter to the software initial value.
// - Index input affects position only while index enable is set.
// - Qualified index pulse loads reload value when A and B match phase.
// - Start arms once; later position reads return live count, counting continues.
// - Read while not armed in direct mode starts, samples and stops; no position retained.
// - Buffered mode captures position on each active sample clock edge while armed, in order; a full buffer drops the sample.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`include "encoder_position_capture_regs.svh"

module encoder_position_capture
	import encoder_position_capture_pkg::*;
(
	input  logic        pclk,
	input  logic        presetn,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [7:0]  paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	input  logic        enc_a,
	input  logic        enc_b,
	input  logic        enc_z,
	input  logic        sample_clk
);

	epc_s        q;
	epc_s        d;
	logic [3:0]  pin;
	logic        pa;
	logic        pb;
	logic        pz;
	logic        ps;
	logic        acc;
	logic        done;
	logic        run;
	logic        step;
	logic        up;
	logic        z_load;
	logic        s_edge;
	logic        push;
	logic        pop;
	logic        cmd_wr;
	logic        start;
	logic        stop;
	logic        implicit;
	logic        full;
	logic [31:0] rd_word;

	// The sample clock is an ordinary pin sampled on pclk
	pin_sync u_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_raw   ({sample_clk, enc_z, enc_b, enc_a}),
		.pin_clean (pin)
	);

	assign pa = pin[`PIN_A];
	assign pb = pin[`PIN_B];
	assign pz = pin[`PIN_Z];
	assign ps = pin[`PIN_S];

	// First access cycle prepares the answer, the second completes it
	assign acc      = psel && penable && !q.pready;
	assign done     = psel && penable && q.pready;
	assign run      = (q.st == ST_RUN);
	assign step     = (pa ^ q.a) ^ (pb ^ q.b);
	assign up       = pa ^ q.b;
	assign z_load   = run && q.zen && pz && !q.z && ({pb, pa} == q.zph);
	assign s_edge   = q.sfall ? (q.s && !ps) : (!q.s && ps);
	assign push     = run && q.mode && s_edge;
	assign full     = (q.cnt == `CNT_DEPTH);
	assign pop      = done && !pwrite && (paddr == `REG_SAMPLE) && (q.cnt != `CNT_ZERO);
	assign cmd_wr   = done && pwrite && (paddr == `REG_CMD);
	assign start    = cmd_wr && pwdata[`CMD_START];
	assign stop     = cmd_wr && pwdata[`CMD_STOP] && !start;
	assign implicit = done && !pwrite && (paddr == `REG_POS) && !run && !q.mode;

	always_comb begin
		rd_word = `WORD_ZERO;
		case (paddr)
			`REG_CTRL: begin
				rd_word[`CTRL_MODE] = q.mode;
				rd_word[`CTRL_ZEN] = q.zen;
				rd_word[`CTRL_ZPH_HI:`CTRL_ZPH_LO] = q.zph;
				rd_word[`CTRL_SFALL] = q.sfall;
			end
			`REG_INIT: begin
				rd_word = q.init;
			end
			`REG_RELOAD: begin
				rd_word = q.reload;
			end
			`REG_POS: begin
				// Unarmed on-demand read answers with the freshly preset value
				rd_word = (!run && !q.mode) ? q.init : q.pos;
			end
			`REG_STATUS: begin
				rd_word[`STAT_ARMED] = run;
				rd_word[`STAT_EMPTY] = (q.cnt == `CNT_ZERO);
				rd_word[`STAT_FULL] = full;
				rd_word[`STAT_OVF] = q.ovf;
				rd_word[`STAT_CNT_HI:`STAT_CNT_LO] = q.cnt;
			end
			`REG_SAMPLE: begin
				if (q.cnt != `CNT_ZERO) begin
					rd_word = q.mem[q.rd];
				end
			end
			default: begin
				rd_word = `WORD_ZERO;
			end
		endcase
	end

	always_comb begin
		d = q;
		d.pready = 1'b0;
		d.a = pa;
		d.b = pb;
		d.z = pz;
		d.s = ps;

		if (acc) begin
			d.pready = 1'b1;
			d.prdata = rd_word;
			d.pslverr = !((paddr == `REG_CTRL) || (paddr == `REG_CMD) || (paddr == `REG_INIT) ||
				(paddr == `REG_RELOAD) || (paddr == `REG_POS) || (paddr == `REG_STATUS) ||
				(paddr == `REG_SAMPLE));
		end else if (!q.pready) begin
			d.pslverr = 1'b0;
		end

		// Counting while armed; index load has priority over a quadrature step
		if (run) begin
			if (z_load) begin
				d.pos = q.reload;
			end else if (step) begin
				d.pos = up ? q.pos + `POS_ONE : q.pos - `POS_ONE;
			end
		end

		if (done && pwrite) begin
			case (paddr)
				`REG_CTRL: begin
					d.mode = pwdata[`CTRL_MODE];
					d.zen = pwdata[`CTRL_ZEN];
					d.zph = pwdata[`CTRL_ZPH_HI:`CTRL_ZPH_LO];
					d.sfall = pwdata[`CTRL_SFALL];
				end
				`REG_INIT: begin
					d.init = pwdata;
				end
				`REG_RELOAD: begin
					d.reload = pwdata;
				end
				`REG_STATUS: begin
					if (pwdata[`STAT_OVF]) begin
						d.ovf = 1'b0;
					end
				end
				default: begin
					d.st = q.st;
				end
			endcase
		end

		if (start) begin
			d.st = ST_RUN;
			d.pos = q.init;
		end else if (stop) begin
			d.st = ST_IDLE;
		end

		// One-shot start and stop around a read of an unarmed counter
		if (implicit) begin
			d.pos = q.init;
			d.st = ST_IDLE;
		end

		// Captured samples are kept in arrival order; a full buffer drops and flags
		if (push) begin
			if (full && !pop) begin
				d.ovf = 1'b1;
			end else begin
				d.mem[q.wr] = q.pos;
				d.wr = q.wr + `PTR_ONE;
			end
		end
		if (pop) begin
			d.rd = q.rd + `PTR_ONE;
		end
		d.cnt = q.cnt + {3'h0, push && !(full && !pop)} - {3'h0, pop};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.st <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

	assign prdata  = q.prdata;
	assign pready  = q.pready;
	assign pslverr = q.pslverr;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_start_preset: assert property (start |=> (q.pos == $past(q.init)) && (q.st == ST_RUN))
		else $error("start did not preset position");

	chk_index_ignored: assert property (run && !q.zen && pz && !q.z && !step && !cmd_wr |=> $stable(q.pos))
		else $error("index changed position while disabled");

	chk_index_reload: assert property (z_load && !start |=> q.pos == $past(q.reload))
		else $error("qualified index did not reload");

	chk_index_phase: assert property (run && q.zen && pz && !q.z && ({pb, pa} != q.zph) && !step && !cmd_wr
		|=> $stable(q.pos))
		else $error("index reloaded outside phase");

	chk_read_live: assert property (acc && !pwrite && (paddr == `REG_POS) && run
		|=> (q.prdata == $past(q.pos)) ##1 (q.st == ST_RUN))
		else $error("armed read wrong or disarmed");

	chk_implicit_read: assert property (acc && !pwrite && (paddr == `REG_POS) && !run && !q.mode
		|=> (q.prdata == $past(q.init)) ##1 ((q.st == ST_IDLE) && (q.pos == $past(q.init, 2))))
		else $error("unarmed read not one-shot");

	chk_capture_order: assert property (push && !full && !cmd_wr
		|=> (q.mem[$past(q.wr)] == $past(q.pos)) && (q.wr == $past(q.wr) + `PTR_ONE))
		else $error("sample not appended in order");

	chk_decode_up: assert property (run && step && up && !z_load && !cmd_wr && !implicit
		|=> q.pos == $past(q.pos) + `POS_ONE)
		else $error("forward step did not increment");

	chk_decode_down: assert property (run && step && !up && !z_load && !cmd_wr && !implicit
		|=> q.pos == $past(q.pos) - `POS_ONE)
		else $error("reverse step did not decrement");

	chk_apb_answer: assert property (acc |=> q.pready ##1 !q.pready)
		else $error("ready not a single cycle");

	// Disarm, idle hold and bus answer timing
	chk_stop_disarm: assert property (stop |=> q.st == ST_IDLE)
		else $error("stop did not disarm");

	chk_idle_hold: assert property (!run && !start && !implicit |=> $stable(q.pos))
		else $error("position moved while not armed");

	chk_ready_idle: assert property (!psel |=> !q.pready)
		else $error("ready without a selected transfer");

	chk_prdata_hold: assert property (!acc |=> $stable(q.prdata))
		else $error("read data changed outside an answer");

	chk_cmd_reads_zero: assert property (acc && !pwrite && (paddr == `REG_CMD)
		|=> (q.prdata == `WORD_ZERO) && !q.pslverr)
		else $error("command register read not zero");

	// Buffer order, count and overflow
	chk_count_push: assert property (push && !full && !pop
		|=> q.cnt == $past(q.cnt) + `CNT_ONE)
		else $error("push did not count");

	chk_overflow_set: assert property (push && full && !pop |=> q.ovf && (q.cnt == `CNT_DEPTH))
		else $error("full buffer did not flag overflow");

	chk_pop_order: assert property (pop |=> q.rd == $past(q.rd) + `PTR_ONE)
		else $error("pop did not advance");

	chk_sample_read: assert property (acc && !pwrite && (paddr == `REG_SAMPLE)
		&& (q.cnt != `CNT_ZERO) |=> q.prdata == $past(q.mem[q.rd]))
		else $error("oldest sample not returned");

	chk_sample_empty: assert property (acc && !pwrite && (paddr == `REG_SAMPLE)
		&& (q.cnt == `CNT_ZERO) |=> q.prdata == `WORD_ZERO)
		else $error("empty buffer read not zero");

	chk_cnt_bound: assert property (q.cnt <= `CNT_DEPTH)
		else $error("buffer count beyond depth");

	cov_index_reload: cover property (z_load);
	cov_falling_sample: cover property (push && q.sfall);
	cov_implicit_read: cover property (implicit);
	cov_buffer_full: cover property (push && full);
	cov_sample_pop: cover property (push ##[1:20] pop);

endmodule

/* verification/encoder_sensor_model.sv */
// Quadrature encoder with index pin and external sample clock source
module encoder_sensor_model (
	input  logic pclk,
	output logic enc_a,
	output logic enc_b,
	output logic enc_z,
	output logic sample_clk
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] ph;

	initial begin
		ph = 2'h0;
		{enc_b, enc_a} = 2'h0;
		enc_z = 1'b0;
		sample_clk = 1'b0;
	end

	// Each pin level is held long enough to pass the input filter
	task automatic hold();
		repeat (8) @(posedge pclk);
	endtask

	// Forward goes {B,A} 00-01-11-10, reverse the other way
	task automatic step(input logic fwd);
		ph = fwd ? {ph[0], ~ph[1]} : {~ph[0], ph[1]};
		@(posedge pclk);
		{enc_b, enc_a} <= ph;
		hold();
	endtask

	task automatic pulse_z();
		@(posedge pclk);
		enc_z <= 1'b1;
		hold();
		enc_z <= 1'b0;
		hold();
	endtask

	// Sample clock only moves on request; no free-running source
	task automatic pulse_s();
		@(posedge pclk);
		sample_clk <= 1'b1;
		hold();
		sample_clk <= 1'b0;
		hold();
	endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the encoder position block
`include "encoder_position_capture_regs.svh"

module tb_top
	import encoder_position_capture_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        enc_a;
	logic        enc_b;
	logic        enc_z;
	logic        sample_clk;
	logic        err;
	int          mismatches;
	int          check_count;

	encoder_position_capture i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .sample_clk(sample_clk)
	);

	encoder_sensor_model i_enc (
		.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .sample_clk(sample_clk)
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic stop_test();
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			$display("BAD %0t no pready", $time);
			stop_test();
		end else begin
			r = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0000_0000, r);
		chk(r, e);
	endtask

	task automatic s_count();
		wr(`REG_INIT, 32'h0000_0010);
		rd(`REG_INIT, 32'h0000_0010);
		wr(`REG_CTRL, 32'h0000_0000);
		wr(`REG_CMD, 32'h0000_0001);
		rd(`REG_POS, 32'h0000_0010);
		rd(`REG_STATUS, 32'h0000_0003);
		rd(`REG_CMD, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0000);
		repeat (3) i_enc.step(1'b1);
		rd(`REG_POS, 32'h0000_0013);
		repeat (2) i_enc.step(1'b0);
		rd(`REG_POS, 32'h0000_0011);
	endtask

	task automatic s_index();
		wr(`REG_RELOAD, 32'h0000_0100);
		rd(`REG_RELOAD, 32'h0000_0100);
		i_enc.pulse_z();
		rd(`REG_POS, 32'h0000_0011);
		wr(`REG_CTRL, {28'h0, ~i_enc.ph, 2'h2});
		i_enc.pulse_z();
		rd(`REG_POS, 32'h0000_0011);
		wr(`REG_CTRL, {28'h0, i_enc.ph, 2'h2});
		rd(`REG_CTRL, {28'h0, i_enc.ph, 2'h2});
		i_enc.pulse_z();
		rd(`REG_POS, 32'h0000_0100);
		i_enc.step(1'b1);
		rd(`REG_POS, 32'h0000_0101);
	endtask

	task automatic s_ondemand();
		wr(`REG_CTRL, 32'h0000_0000);
		wr(`REG_CMD, 32'h0000_0002);
		rd(`REG_STATUS, 32'h0000_0002);
		rd(`REG_POS, 32'h0000_0010);
		repeat (2) i_enc.step(1'b1);
		rd(`REG_POS, 32'h0000_0010);
		rd(`REG_STATUS, 32'h0000_0002);
		// Start and stop in one write: start wins
		wr(`REG_CMD, 32'h0000_0003);
		rd(`REG_STATUS, 32'h0000_0003);
		rd(`REG_POS, 32'h0000_0010);
	endtask

	task automatic s_buffer();
		wr(`REG_INIT, 32'h0000_0020);
		wr(`REG_CTRL, 32'h0000_0001);
		wr(`REG_CMD, 32'h0000_0001);
		for (int i = 0; i < 3; i++) begin
			i_enc.pulse_s();
			i_enc.step(1'b1);
		end
		rd(`REG_STATUS, 32'h0000_0301);
		for (int i = 0; i < 3; i++) begin
			rd(`REG_SAMPLE, 32'h0000_0020 + i);
		end
		rd(`REG_SAMPLE, 32'h0000_0000);
		repeat (9) i_enc.pulse_s();
		rd(`REG_STATUS, 32'h0000_080D);
		repeat (8) rd(`REG_SAMPLE, 32'h0000_0023);
		rd(`REG_STATUS, 32'h0000_000B);
		rd(8'h40, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		rd(`REG_CTRL, 32'h0000_0001);
		chk({31'h0, err}, 32'h0000_0000);
		// Overflow clears by writing one; then capture on the falling edge
		wr(`REG_STATUS, 32'h0000_0008);
		rd(`REG_STATUS, 32'h0000_0003);
		wr(`REG_CTRL, 32'h0000_0011);
		i_enc.pulse_s();
		rd(`REG_STATUS, 32'h0000_0101);
		rd(`REG_SAMPLE, 32'h0000_0023);
	endtask

	// Reset in mid-run returns every setting and the counter to idle
	task automatic s_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(`REG_STATUS, 32'h0000_0002);
		rd(`REG_CTRL, 32'h0000_0000);
		rd(`REG_INIT, 32'h0000_0000);
		rd(`REG_POS, 32'h0000_0000);
	endtask

	initial begin
		mismatches = 0;
		check_count = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		s_count();
		s_index();
		s_ondemand();
		s_buffer();
		s_reset();
		stop_test();
	end
endmodule
